/* File: hw/erx_pkg.sv */
// Purpose: Shared constants for the receive backplane interface control block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Link clock runs at 16 phases per 2.048MHz base-rate bit
package erx_pkg;
	// Register word indices and bus decode
	localparam int unsigned ADR_W          = 12;
	localparam logic [9:0]  IDX_TP_CTRL    = 10'h121;
	localparam logic [9:0]  IDX_RX_IF      = 10'h122;
	localparam logic [9:0]  IDX_EXT        = 10'h123;

	// Test pattern control fields
	localparam int unsigned TP_UNFRAMED    = 0;
	localparam int unsigned TP_BER_LO      = 1;
	localparam int unsigned TP_BER_HI      = 2;
	localparam int unsigned TP_SWAP        = 3;

	// Receive interface control fields
	localparam int unsigned RI_MUX         = 2;
	localparam int unsigned RI_INV         = 3;
	localparam int unsigned RI_FRAC        = 4;
	localparam int unsigned RI_GAP         = 5;
	localparam int unsigned RI_RSV6        = 6;
	localparam int unsigned RI_RSV7        = 7;

	// Extension register fields
	localparam int unsigned EXT_HS         = 0;
	localparam int unsigned EXT_CLK_OE     = 1;
	localparam int unsigned EXT_ST_RXGEN   = 4;
	localparam int unsigned EXT_ST_TXGEN   = 5;

	// Values after reset and write masks
	localparam logic [7:0]  TP_CTRL_RST    = 8'h00;
	localparam logic [7:0]  RX_IF_RST      = 8'h00;
	localparam logic [7:0]  EXT_RST        = 8'h02;
	localparam logic [7:0]  TP_CTRL_WMASK  = 8'h0F;
	localparam logic [7:0]  RX_IF_WMASK    = 8'hBC;
	localparam logic [7:0]  EXT_WMASK      = 8'h03;

	// Link timing
	localparam int unsigned LINK_RATE_KHZ  = 32768;
	localparam int unsigned BIT_RATE_KHZ   = 2048;
	localparam int unsigned MUX_RATE_KHZ   = 16384;
	localparam int unsigned PHASES_PER_BIT = LINK_RATE_KHZ / BIT_RATE_KHZ;
	localparam logic [3:0]  PH_LAST        = 4'(PHASES_PER_BIT - 1);
	localparam logic [3:0]  PH_RISE        = 4'h0;
	localparam logic [3:0]  PH_FALL        = 4'(PHASES_PER_BIT / 2);
	localparam logic [7:0]  FRAME_LAST     = 8'hFF;
	localparam logic [7:0]  OVH_BITS       = 8'h08;
	localparam logic [14:0] PRBS_SEED      = 15'h7FFF;
endpackage

/* File: hw/erx_sync.sv */
// Purpose: Two-flop level synchroniser for a bundle of independent bits
// Assumes: Each bit is a quasi-static level; no bus coherency between bits
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module erx_sync #(
	parameter int unsigned W = 1
) (
	// Destination clock
	input  wire logic         clk_i,
	// Level in, level out
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk_i) begin
		meta_r <= d_i;
		q_r    <= meta_r;
	end

	assign q_o = q_r;
endmodule
`default_nettype wire

/* File: hw/erx_ctrl.sv */
// Purpose: Receive backplane interface and unframed test-pattern control
// Assumes: Classic Wishbone slave on clk_i; link logic on link_clk_i
// Notes:   Control crosses as quasi-static levels; software should not expect glitch-free mode changes
// Summary of operation
// RL1: Swap set: receive generates pattern to backplane, transmit monitors; clear reverses.
// RL2: Unframed and no swap: transmit sends pattern in every slot and framing bit.
// RL3: Unframed with swap: receive drives unframed pattern on backplane; clear disables.
// RL4: Serial clock output, gapping off: continuous 2.048MHz clock.
// RL5: Gapping on: 2.048MHz clock only on payload bits, held low on overhead.
// RL6: Base rate: fractional enable turns signaling and recovered-clock outputs on or off.
// RL7: High-speed or mux: enable ignored, both outputs always active.
// RL8: Edge invert 0 changes data on rising clock, 1 on falling clock.
// RL9: Edge inversion acts only at base rate.
// RL10: Mux enable puts four channels on one 16.384MHz serial stream.
// RL11: Receive interface bits 7 and 6 have no effect on behaviour.
`timescale 1ns/1ps
`default_nettype none
module erx_ctrl (
	// System clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Pattern role indicators
	output logic             tx_pattern_gen_o,
	output logic             tx_pattern_mon_o,
	output logic             rx_pattern_gen_o,
	output logic             rx_pattern_mon_o,
	// Link side
	input  wire logic        link_clk_i,
	input  wire logic [3:0]  line_data_i,
	input  wire logic [3:0]  line_sig_i,
	output logic             tx_line_pattern_o,
	output logic             rx_serial_clock_pin_o,
	output logic             rx_serial_clock_pin_oe_o,
	output logic             rx_serial_data_pin_o,
	output logic             rx_signaling_pin_o,
	output logic             rx_recovered_clock_pin_o
);
	// Register file
	logic [7:0]  tp_ctrl_r;
	logic [7:0]  rx_if_r;
	logic [7:0]  ext_r;
	logic        ack_r;
	logic [31:0] dat_r;
	logic [1:0]  st_sync;
	logic        req;
	logic [9:0]  idx;

	function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] msk);
		wmerge = (old & ~msk) | (nw & msk);
	endfunction

	function automatic logic base_rate(input logic mux, input logic hs);
		base_rate = !mux && !hs;
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !ack_r;
	assign idx = wb_adr_i[11:2];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req;
		end
	end

	// Writes land on the edge at which the master samples ack, never before it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tp_ctrl_r <= erx_pkg::TP_CTRL_RST;
			rx_if_r   <= erx_pkg::RX_IF_RST;
			ext_r     <= erx_pkg::EXT_RST;
		end else if (wb_cyc_i && wb_stb_i && wb_we_i && ack_r && wb_sel_i[0]) begin
			if (idx == erx_pkg::IDX_TP_CTRL) begin
				tp_ctrl_r <= wmerge(tp_ctrl_r, wb_dat_i[7:0], erx_pkg::TP_CTRL_WMASK);
			end
			if (idx == erx_pkg::IDX_RX_IF) begin
				rx_if_r <= wmerge(rx_if_r, wb_dat_i[7:0], erx_pkg::RX_IF_WMASK); // [RL11]
			end
			if (idx == erx_pkg::IDX_EXT) begin
				ext_r <= wmerge(ext_r, wb_dat_i[7:0], erx_pkg::EXT_WMASK);
			end
		end
	end

	// Unmapped words read as zero and still acknowledge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			case (idx)
				erx_pkg::IDX_TP_CTRL: dat_r <= {24'h000000, tp_ctrl_r};
				erx_pkg::IDX_RX_IF:   dat_r <= {24'h000000, rx_if_r};
				erx_pkg::IDX_EXT:     dat_r <= {24'h000000, 2'b00, st_sync, 2'b00, ext_r[1:0]};
				default:              dat_r <= 32'h0000_0000;
			endcase
		end
	end

	// Pattern roles follow the swap bit directly
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_pattern_gen_o <= 1'b0;
			tx_pattern_mon_o <= 1'b0;
			rx_pattern_gen_o <= 1'b0;
			rx_pattern_mon_o <= 1'b0;
		end else begin
			tx_pattern_gen_o <= !tp_ctrl_r[erx_pkg::TP_SWAP]; // [RL1]
			rx_pattern_mon_o <= !tp_ctrl_r[erx_pkg::TP_SWAP]; // [RL1]
			rx_pattern_gen_o <= tp_ctrl_r[erx_pkg::TP_SWAP];  // [RL1]
			tx_pattern_mon_o <= tp_ctrl_r[erx_pkg::TP_SWAP];  // [RL1]
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	// Crossing into the link domain: reset, configuration, line pins
	logic [15:0] to_link;
	logic [15:0] lk;
	logic        lrst;
	logic        l_unf;
	logic        l_swap;
	logic        l_gap;
	logic        l_frac;
	logic        l_inv;
	logic        l_mux;
	logic        l_hs;
	logic        l_oe;
	logic [3:0]  l_data;
	logic [3:0]  l_sig;

	assign to_link = {line_sig_i, line_data_i, rst_i, ext_r[erx_pkg::EXT_CLK_OE], ext_r[erx_pkg::EXT_HS],
		rx_if_r[erx_pkg::RI_MUX], rx_if_r[erx_pkg::RI_INV], rx_if_r[erx_pkg::RI_FRAC],
		rx_if_r[erx_pkg::RI_GAP], tp_ctrl_r[erx_pkg::TP_SWAP] && tp_ctrl_r[erx_pkg::TP_UNFRAMED]};

	erx_sync #(.W(16)) u_to_link (
		.clk_i (link_clk_i),
		.d_i   (to_link),
		.q_o   (lk)
	);

	assign l_swap = lk[0];
	assign l_gap  = lk[1];
	assign l_frac = lk[2];
	assign l_inv  = lk[3];
	assign l_mux  = lk[4];
	assign l_hs   = lk[5];
	assign l_oe   = lk[6];
	assign lrst   = lk[7];
	assign l_data = lk[11:8];
	assign l_sig  = lk[15:12];

	// Unframed-without-swap needs its own level, so derive it from a separate crossing
	logic [0:0] unf_tx_l;
	erx_sync #(.W(1)) u_unf (
		.clk_i (link_clk_i),
		.d_i   (tp_ctrl_r[erx_pkg::TP_UNFRAMED] && !tp_ctrl_r[erx_pkg::TP_SWAP]),
		.q_o   (unf_tx_l)
	);
	assign l_unf = unf_tx_l[0];

	// Link timing: 16 phases per base bit, 256 bits per frame
	logic [3:0]  phase_r;
	logic [7:0]  bit_r;
	logic [14:0] prbs_r;
	logic [3:0]  hold_r;
	logic [3:0]  sig_hold_r;
	logic        base;
	logic        ovh;
	logic        upd;
	logic [1:0]  ch;

	assign base = base_rate(l_mux, l_hs);
	assign ovh  = bit_r < erx_pkg::OVH_BITS;
	assign ch   = phase_r[3:2];
	// Inversion moves the update to the falling edge, base rate only
	assign upd  = l_mux ? !phase_r[0]
		: (phase_r == ((base && l_inv) ? erx_pkg::PH_FALL : erx_pkg::PH_RISE)); // [RL8] [RL9]

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			phase_r <= 4'h0;
			bit_r   <= 8'h00;
		end else begin
			phase_r <= phase_r + 4'h1;
			if (phase_r == erx_pkg::PH_LAST) begin
				bit_r <= (bit_r == erx_pkg::FRAME_LAST) ? 8'h00 : bit_r + 8'h01;
			end
		end
	end

	// Pattern advances once per bit and ignores framing, so it fills every slot
	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			prbs_r <= erx_pkg::PRBS_SEED;
		end else if (phase_r == erx_pkg::PH_LAST) begin
			prbs_r <= {prbs_r[13:0], prbs_r[14] ^ prbs_r[13]};
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			hold_r     <= 4'h0;
			sig_hold_r <= 4'h0;
		end else if (phase_r == erx_pkg::PH_LAST) begin
			hold_r     <= l_data;
			sig_hold_r <= l_sig;
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			tx_line_pattern_o <= 1'b0;
		end else begin
			tx_line_pattern_o <= l_unf && prbs_r[0]; // [RL2]
		end
	end

	// Gapping holds the clock low through the overhead timeslot
	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			rx_serial_clock_pin_o    <= 1'b0;
			rx_serial_clock_pin_oe_o <= 1'b0;
		end else begin
			rx_serial_clock_pin_oe_o <= l_oe;
			rx_serial_clock_pin_o    <= (l_mux ? !phase_r[0] : !phase_r[3]) // [RL4] [RL10]
				&& !(l_gap && ovh); // [RL5]
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			rx_serial_data_pin_o <= 1'b0;
		end else if (upd) begin
			if (l_swap) begin
				rx_serial_data_pin_o <= prbs_r[0]; // [RL3]
			end else if (l_mux) begin
				rx_serial_data_pin_o <= hold_r[ch]; // [RL10]
			end else begin
				rx_serial_data_pin_o <= hold_r[0];
			end
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (lrst) begin
			rx_signaling_pin_o       <= 1'b0;
			rx_recovered_clock_pin_o <= 1'b0;
		end else if (!base || l_frac) begin // [RL6] [RL7]
			rx_signaling_pin_o       <= l_mux ? sig_hold_r[ch] : sig_hold_r[0];
			rx_recovered_clock_pin_o <= !phase_r[3];
		end else begin
			rx_signaling_pin_o       <= 1'b0;
			rx_recovered_clock_pin_o <= 1'b0;
		end
	end

	// Generator activity back to the register domain for readback
	erx_sync #(.W(2)) u_to_sys (
		.clk_i (clk_i),
		.d_i   ({l_unf, l_swap}),
		.q_o   (st_sync)
	);

	a_rx_role_swap: assert property (@(posedge clk_i) disable iff (rst_i)
		rx_pattern_gen_o |-> (tx_pattern_mon_o && !tx_pattern_gen_o)) // [RL1]
		else $error("pattern roles not swapped together");

	a_tx_line_pat: assert property (@(posedge link_clk_i) disable iff (lrst)
		!l_unf |=> !tx_line_pattern_o) // [RL2]
		else $error("transmit pattern active while disabled");

	a_rx_unframed_data: assert property (@(posedge link_clk_i) disable iff (lrst)
		(l_swap && upd) |=> (rx_serial_data_pin_o == $past(prbs_r[0]))) // [RL3]
		else $error("backplane data is not the pattern");

	a_cont_clock_high: assert property (@(posedge link_clk_i) disable iff (lrst)
		(!l_gap && !l_mux) |=> (rx_serial_clock_pin_o == ($past(phase_r) < erx_pkg::PH_FALL))) // [RL4]
		else $error("continuous clock high phase wrong");

	a_gap_overhead: assert property (@(posedge link_clk_i) disable iff (lrst)
		(l_gap && ovh) |=> !rx_serial_clock_pin_o) // [RL5]
		else $error("clock edge during overhead bits");

	a_sig_base_off: assert property (@(posedge link_clk_i) disable iff (lrst)
		(base && !l_frac) [*2] |-> (!rx_signaling_pin_o && !rx_recovered_clock_pin_o)) // [RL6]
		else $error("signaling outputs active while disabled");

	a_rec_clk_forced: assert property (@(posedge link_clk_i) disable iff (lrst)
		(!base && phase_r == 4'h3) |=> rx_recovered_clock_pin_o) // [RL7]
		else $error("recovered clock missing in fast modes");

	a_edge_falling: assert property (@(posedge link_clk_i) disable iff (lrst)
		($past(base) && $past(l_inv) && !$past(l_gap) && $changed(rx_serial_data_pin_o))
		|-> !rx_serial_clock_pin_o) // [RL8]
		else $error("data changed away from falling edge");

	a_mux_edge_rise: assert property (@(posedge link_clk_i) disable iff (lrst)
		($past(l_mux) && $past(l_inv) && !$past(l_gap) && $changed(rx_serial_data_pin_o))
		|-> rx_serial_clock_pin_o) // [RL9]
		else $error("inversion acted in multiplexed mode");

	a_mux_clk_rate: assert property (@(posedge link_clk_i) disable iff (lrst)
		(l_mux && !l_gap) [*3] |-> (rx_serial_clock_pin_o != $past(rx_serial_clock_pin_o))) // [RL10]
		else $error("multiplexed clock not at full rate");

	a_rsv6_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		(req && !wb_we_i && idx == erx_pkg::IDX_RX_IF) |=> !wb_dat_o[6]) // [RL11]
		else $error("reserved bit 6 read back as one");
endmodule
`default_nettype wire

/* File: verification/erx_bp_model.sv */
// Purpose: Backplane receiver model that counts clock edges and data levels
// Assumes: Counting runs while win_i is high, in the link domain
// Notes:   The first window cycle clears the counts, so a window of N+1 cycles counts N
`timescale 1ns/1ps
`default_nettype none
module erx_bp_model (
	// Link clock and window control
	input  wire logic link_clk_i,
	input  wire logic win_i,
	input  wire logic fall_i,
	// Backplane pins
	input  wire logic sclk_i,
	input  wire logic sdata_i,
	input  wire logic sig_i,
	input  wire logic rclk_i,
	// Counts
	output var  int   edges_o,
	output var  int   ones_o,
	output var  int   sones_o,
	output var  int   redges_o,
	output var  int   bad_o
);
	logic win_r;
	logic sclk_r;
	logic rclk_r;
	logic sdata_r;
	always_ff @(posedge link_clk_i) begin
		win_r   <= win_i;
		sclk_r  <= sclk_i;
		rclk_r  <= rclk_i;
		sdata_r <= sdata_i;
		if (win_i && !win_r) begin
			edges_o  <= 0;
			ones_o   <= 0;
			sones_o  <= 0;
			redges_o <= 0;
			bad_o    <= 0;
		end else if (win_i) begin
			edges_o  <= edges_o + int'(sclk_i && !sclk_r);
			ones_o   <= ones_o + int'(sdata_i);
			sones_o  <= sones_o + int'(sig_i);
			redges_o <= redges_o + int'(rclk_i && !rclk_r);
			// A data move without the selected clock edge would be sampled wrongly
			if (sdata_i != sdata_r && (sclk_i == sclk_r || sclk_i == fall_i))
				bad_o <= bad_o + 1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the receive backplane control block
// Assumes: Wishbone answers one cycle after a request is taken
// Notes:   Link timing is judged over 4096-cycle windows, exactly one frame
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [11:0] A_TP  = {erx_pkg::IDX_TP_CTRL, 2'b00};
	localparam logic [11:0] A_RI  = {erx_pkg::IDX_RX_IF, 2'b00};
	localparam logic [11:0] A_EXT = {erx_pkg::IDX_EXT, 2'b00};
	logic        clk_i = 1'b0;
	logic        link_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tog = 1'b0, win = 1'b0, fall = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [7:0]  wdat = 8'h00, q;
	logic [3:0]  ldat = 4'h1;
	logic [3:0]  ld_base = 4'h1;
	logic [31:0] dat_o;
	logic        ack, tgen, tmon, rgen, rmon, tpat, sclk, oe, sdat, sig, rclk;
	int          edges, ones, sones, redges, bad, tp_ones;
	int          err_count = 0;
	int          tests_run = 0;
	always #50 clk_i = ~clk_i;
	always #6 link_clk_i = ~link_clk_i;
	always @(posedge clk_i) ldat <= tog ? ~ldat : ld_base;
	erx_ctrl u_erx_ctrl (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i({24'h000000, wdat}), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.tx_pattern_gen_o(tgen), .tx_pattern_mon_o(tmon), .rx_pattern_gen_o(rgen), .rx_pattern_mon_o(rmon),
		.link_clk_i(link_clk_i), .line_data_i(ldat), .line_sig_i(ldat), .tx_line_pattern_o(tpat),
		.rx_serial_clock_pin_o(sclk), .rx_serial_clock_pin_oe_o(oe), .rx_serial_data_pin_o(sdat),
		.rx_signaling_pin_o(sig), .rx_recovered_clock_pin_o(rclk));
	erx_bp_model u_erx_bp_model (
		.link_clk_i(link_clk_i), .win_i(win), .fall_i(fall), .sclk_i(sclk), .sdata_i(sdat), .sig_i(sig),
		.rclk_i(rclk), .edges_o(edges), .ones_o(ones), .sones_o(sones), .redges_o(redges), .bad_o(bad));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value t=%0t %s got %0h exp %0h", $time, msg, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 16);
		// A missing answer counts as a mismatch and ends the run
		if (n == 16) begin
			err_count++;
			$display("wrong value t=%0t no bus answer", $time);
			test_done;
		end
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// Second idle edge lets registered outputs follow a write before they are compared
		repeat (2) @(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		chk(32'(q), 32'(exp), "register read");
	endtask
	task automatic run(input logic [7:0] ri, input logic [3:0] ld, input logic t, input logic f,
		input int e_edg, input int e_one, input int e_sig, input int e_rcl, input logic cb);
		xfer(1'b1, A_RI, ri);
		ld_base <= ld;
		tog <= t;
		fall <= f;
		repeat (40) @(posedge link_clk_i);
		win <= 1'b1;
		tp_ones = 0;
		repeat (4097) begin
			@(posedge link_clk_i);
			tp_ones += int'(tpat);
		end
		win <= 1'b0;
		@(posedge clk_i);
		tog <= 1'b0;
		if (e_edg >= 0) chk(edges, e_edg, "serial clock edges");
		if (e_one >= 0) chk(ones, e_one, "serial data ones");
		if (e_sig >= 0) chk(sones, e_sig, "signaling ones");
		if (e_rcl >= 0) chk(redges, e_rcl, "recovered clock edges");
		if (cb) chk(bad, 0, "data edge");
		$display("test run %0h done", ri);
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		err_count++;
		$display("wrong value t=%0t watchdog expired", $time);
		test_done;
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(32'({tgen, tmon, rgen, rmon, oe}), 32'h13, "reset roles");
		rd(A_TP, 8'h00);
		rd(A_RI, 8'h00);
		rd(A_EXT, 8'h02);
		xfer(1'b1, A_TP, 8'hFF);
		rd(A_TP, 8'h0F);
		xfer(1'b1, A_RI, 8'hFF);
		rd(A_RI, 8'hBC);
		xfer(1'b1, 12'hFFC, 8'hFF);
		rd(12'hFFC, 8'h00);
		xfer(1'b1, A_TP, 8'h08);
		chk(32'({tgen, tmon, rgen, rmon}), 32'h6, "swapped roles");
		$display("test registers done");
		xfer(1'b1, A_TP, 8'h01);
		chk(32'({tgen, tmon, rgen, rmon}), 32'h9, "plain roles");
		run(8'h00, 4'h1, 1'b0, 1'b0, -1, -1, -1, -1, 1'b0);
		chk(32'(tp_ones > 0), 32'h1, "line pattern runs");
		rd(A_EXT, 8'h22);
		xfer(1'b1, A_TP, 8'h09);
		run(8'h00, 4'hF, 1'b0, 1'b0, -1, -1, -1, -1, 1'b0);
		chk(32'(tp_ones), 32'h0, "line pattern idle");
		chk(32'(ones < 4000), 32'h1, "backplane pattern");
		rd(A_EXT, 8'h12);
		xfer(1'b1, A_TP, 8'h00);
		$display("test pattern done");
		run(8'h80, 4'h1, 1'b0, 1'b0, 256, 4096, 0, 0, 1'b0);
		rd(A_EXT, 8'h02);
		run(8'h20, 4'h1, 1'b0, 1'b0, 248, 4096, -1, -1, 1'b0);
		run(8'h10, 4'h1, 1'b0, 1'b0, 256, -1, 4096, 256, 1'b0);
		run(8'h00, 4'h1, 1'b1, 1'b0, 256, -1, -1, -1, 1'b1);
		run(8'h08, 4'h1, 1'b1, 1'b1, -1, -1, -1, -1, 1'b1);
		run(8'h0C, 4'h1, 1'b1, 1'b0, 2048, -1, -1, -1, 1'b1);
		xfer(1'b1, A_EXT, 8'h03);
		rd(A_EXT, 8'h03);
		run(8'h08, 4'h1, 1'b1, 1'b0, 256, -1, -1, 256, 1'b1);
		xfer(1'b1, A_EXT, 8'h02);
		run(8'h04, 4'h1, 1'b0, 1'b0, 2048, 1024, 1024, 256, 1'b0);
		test_done;
	end
endmodule
`default_nettype wire
